// ===== inc/fec_cfg.svh
// Register offsets, field positions and reset values of the repair classifier
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_WINDOW 8'h04
`define OFS_PKTTIME 8'h08
`define OFS_STATUS 8'h0C
`define OFS_ACCEPT 8'h10
`define OFS_DISCARD 8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_SCHEME_LSB 4
`define CTRL_RST_EN 1'b1
`define SCHEME_XOR 4'h0
`define WINDOW_RST 32'h0000_2710
`define PKTTIME_RST 16'h0001
`define HDR_R_BIT 31
`define HSIZE_WORD 3'h2

`endif

// ===== inc/fec_if.sv
// Carrier between the classifier core, its grid decoder and its counters
`timescale 1ns/10ps
interface fec_if;
  import fec_pkg::*;
  logic [7:0] stride;
  logic [7:0] rep;
  logic [15:0] pkt_us;
  logic [31:0] window;
  class_e cls;
  logic [15:0] span;
  logic too_long;
  logic pkt_done;
  logic pkt_ok;
  logic clr;
  logic [31:0] acc_cnt;
  logic [31:0] dis_cnt;
  modport dec (input stride, rep, pkt_us, window, output cls, span, too_long);
  modport stat (input pkt_done, pkt_ok, clr, output acc_cnt, dis_cnt);
endinterface

// ===== inc/fec_pkg.sv
// Types shared by the repair header classifier modules
package fec_pkg;

  // ----------------------------------------------------------------
  // Classes, discard reasons and parser states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_NONE, CLS_ROW, CLS_ROW2D, CLS_COL, CLS_RETX, CLS_MASK, CLS_DROP
  } class_e;

  typedef enum logic [2:0] {
    RSN_NONE, RSN_ZERO_GRID, RSN_WINDOW, RSN_RESERVED, RSN_SCHEME, RSN_TRUNC
  } reason_e;

  typedef enum logic [2:0] {
    PS_IDLE, PS_TS, PS_SSRC, PS_BLK, PS_SKIP
  } parse_e;

  function automatic class_e grid_class(input logic [7:0] stride, input logic [7:0] rep);
    if (stride == 8'h00) begin
      return CLS_DROP;
    end else if (rep == 8'h00) begin
      return (stride == 8'h01) ? CLS_RETX : CLS_ROW;
    end else if (rep == 8'h01) begin
      return CLS_ROW2D;
    end
    return CLS_COL;
  endfunction

endpackage

// ===== src/fec_grid_decode.sv
// Stride and repeat classification with repair window span check
`timescale 1ns/10ps
module fec_grid_decode
  import fec_pkg::*;
(
  fec_if.dec bus
);
  logic [15:0] span;

  // ----------------------------------------------------------------
  // Span of source packets
  // ----------------------------------------------------------------
  always_comb begin
    if (bus.rep > 8'h01) begin
      span = 16'({8'h00, bus.rep - 8'h01} * {8'h00, bus.stride}) + 16'h0001;
    end else begin
      span = {8'h00, bus.stride};
    end
  end

  assign bus.span = span;
  assign bus.cls = grid_class(bus.stride, bus.rep);
  assign bus.too_long = ({16'h0000, span} * {16'h0000, bus.pkt_us}) > bus.window;
endmodule

// ===== src/fec_repair_header_classifier.sv
// Repair header classifier top: AHB-Lite registers and header parser
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "fec_cfg.svh"
// Functional notes
// - Stride and repeat are 8-bit unsigned fields, at most 255.
// - Stride zero with repeat zero: repair block is discarded.
// - Stride one, repeat zero: block is a retransmission of one packet.
// - Stride and repeat may change per packet; no pair is latched.
// - Each per-stream block is decoded on its own pair.
// - Span beyond the session repair window discards the packet.
// - Retransmit set, fixed clear: one-packet retransmission layout.
// - In retransmissions the length field carries the resent sequence number.
// - Retransmissions hold no stride, repeat or mask fields.
// - Retransmission stream SSRC comes from the repair header itself.
// - One repair stream may serve several streams; demultiplex per block.
// - Repair timestamp rate exceeds 1000 Hz, ideally the source rate.
// - Repair window is kept and compared in microseconds.
// - Without a signalled code the XOR parity scheme is assumed.
// - Both variant bits set is reserved; such packets are ignored.
// - Stride above one, zero repeat: row parity over stride packets.
// - Nonzero stride, repeat one: row parity with column parity following.
// - Nonzero stride, repeat above one: column parity, members spaced by the stride.
module fec_repair_header_classifier
  import fec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [31:0] in_data,
  input wire logic [3:0] in_csrc_cnt,
  output logic blk_valid,
  output class_e blk_class,
  output reason_e blk_reason,
  output logic blk_grid,
  output logic [3:0] blk_index,
  output logic [15:0] lowest_seq,
  output logic [7:0] blk_stride,
  output logic [7:0] blk_rep,
  output logic [15:0] blk_span,
  output logic [31:0] blk_ssrc,
  output logic pkt_valid,
  output logic pkt_ok,
  output class_e pkt_variant,
  output reason_e pkt_reason
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    parse_e st;
    logic en;
    logic [3:0] scheme;
    logic [31:0] window;
    logic [15:0] pkt_us;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic hdr_retx;
    logic [3:0] blk_left;
    logic [3:0] blk_num;
    logic [15:0] seq;
    class_e variant;
    reason_e reason;
    logic blk_valid;
    class_e blk_class;
    reason_e blk_reason;
    logic blk_grid;
    logic [3:0] blk_index;
    logic [15:0] blk_seq;
    logic [7:0] blk_stride;
    logic [7:0] blk_rep;
    logic [15:0] blk_span;
    logic [31:0] blk_ssrc;
    logic pkt_valid;
    logic pkt_ok;
    class_e pkt_variant;
    reason_e pkt_reason;
  } core_s;

  function automatic core_s core_rst();
    core_s v;
    v = '0;
    v.en = `CTRL_RST_EN;
    v.scheme = `SCHEME_XOR;
    v.window = `WINDOW_RST;
    v.pkt_us = `PKTTIME_RST;
    return v;
  endfunction

  localparam core_s CORE_RST = core_rst();

  function automatic logic [31:0] reg_read(input logic [7:0] a, input core_s s,
                                           input logic [31:0] acc, input logic [31:0] dis);
    case (a)
      `OFS_CTRL: return {24'h00_0000, s.scheme, 3'h0, s.en};
      `OFS_WINDOW: return s.window;
      `OFS_PKTTIME: return {16'h0000, s.pkt_us};
      `OFS_STATUS: return {22'h00_0000, s.st != PS_IDLE, s.pkt_ok, 1'b0,
                           s.pkt_reason, 1'b0, s.pkt_variant};
      `OFS_ACCEPT: return acc;
      `OFS_DISCARD: return dis;
      default: return 32'h0000_0000;
    endcase
  endfunction

  core_s r, n;
  fec_if link ();

  fec_grid_decode u_dec (
    .bus(link.dec)
  );

  fec_stats u_stats (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .bus(link.stat)
  );

  // pair taken fresh from each block word
  assign link.stride = in_data[15:8];
  assign link.rep = in_data[7:0];
  assign link.pkt_us = r.pkt_us;
  assign link.window = r.window;
  assign link.pkt_done = r.pkt_valid;
  assign link.pkt_ok = r.pkt_ok;
  assign link.clr = r.wr_pend && (r.wr_addr == `OFS_ACCEPT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    reason_e rsn;
    class_e var_c;
    class_e cls;
    logic fin;
    n = r;
    rsn = r.reason;
    var_c = r.variant;
    cls = CLS_NONE;
    fin = 1'b0;
    n.blk_valid = 1'b0;
    n.pkt_valid = 1'b0;
    // Write lands in the data phase; a read just behind it sees old data
    if (r.wr_pend) begin
      case (r.wr_addr)
        `OFS_CTRL: begin
          n.en = hwdata[`CTRL_EN_BIT];
          n.scheme = hwdata[`CTRL_SCHEME_LSB +: 4];
        end
        `OFS_WINDOW: n.window = hwdata;
        `OFS_PKTTIME: n.pkt_us = hwdata[15:0];
        default: n.wr_pend = 1'b0;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      n.wr_pend = hwrite && (hsize == `HSIZE_WORD);
      n.wr_addr = haddr[7:0];
      n.rdata = hwrite ? r.rdata : reg_read(haddr[7:0], r, link.acc_cnt, link.dis_cnt);
    end else begin
      n.wr_pend = 1'b0;
    end
    case (r.st)
      PS_IDLE: begin
        if (in_valid && in_sop && r.en) begin
          n.blk_num = 4'h0;
          n.blk_left = (in_csrc_cnt == 4'h0) ? 4'h1 : in_csrc_cnt;
          // length field holds the resent sequence number
          n.seq = in_data[15:0];
          n.hdr_retx = in_data[`HDR_R_BIT];
          rsn = RSN_NONE;
          var_c = CLS_NONE;
          n.st = PS_SKIP;
          // only the default XOR scheme is decoded
          if (r.scheme != `SCHEME_XOR) begin
            rsn = RSN_SCHEME;
          end else begin
            case (in_data[`HDR_R_BIT -: 2])
              2'h3: rsn = RSN_RESERVED;
              2'h0: var_c = CLS_MASK;
              // retransmission and grid both take the stamp word next
              default: n.st = PS_TS;
            endcase
          end
          if (in_eop) begin
            fin = 1'b1;
            if (n.st == PS_TS) begin
              rsn = RSN_TRUNC;
            end
          end
        end
      end
      PS_TS: begin
        if (in_valid) begin
          n.st = r.hdr_retx ? PS_SSRC : PS_BLK;
          if (in_eop) begin
            fin = 1'b1;
            rsn = RSN_TRUNC;
          end
        end
      end
      PS_SSRC: begin
        if (in_valid) begin
          // no grid fields; stream from header
          n.blk_valid = 1'b1;
          n.blk_class = CLS_RETX;
          n.blk_reason = RSN_NONE;
          n.blk_grid = 1'b0;
          n.blk_index = 4'h0;
          n.blk_seq = r.seq;
          n.blk_stride = 8'h00;
          n.blk_rep = 8'h00;
          n.blk_span = 16'h0001;
          n.blk_ssrc = in_data;
          var_c = CLS_RETX;
          n.st = PS_SKIP;
          fin = in_eop;
        end
      end
      PS_BLK: begin
        if (in_valid) begin
          cls = link.cls;
          n.blk_reason = RSN_NONE;
          if (cls == CLS_DROP) begin
            n.blk_reason = RSN_ZERO_GRID;
          end else if (link.too_long) begin
            cls = CLS_DROP;
            n.blk_reason = RSN_WINDOW;
          end
          n.blk_valid = 1'b1;
          n.blk_class = cls;
          n.blk_grid = 1'b1;
          n.blk_index = r.blk_num;
          n.blk_seq = in_data[31:16];
          n.blk_stride = in_data[15:8];
          n.blk_rep = in_data[7:0];
          n.blk_span = link.span;
          n.blk_ssrc = 32'h0000_0000;
          if (r.blk_num == 4'h0) begin
            var_c = cls;
          end
          if (rsn == RSN_NONE) begin
            rsn = n.blk_reason;
          end
          n.blk_num = r.blk_num + 4'h1;
          n.blk_left = r.blk_left - 4'h1;
          if (r.blk_left == 4'h1) begin
            n.st = PS_SKIP;
            fin = in_eop;
          end else if (in_eop) begin
            fin = 1'b1;
            if (rsn == RSN_NONE) begin
              rsn = RSN_TRUNC;
            end
          end
        end
      end
      PS_SKIP: begin
        if (in_valid && in_eop) begin
          fin = 1'b1;
        end
      end
      default: n.st = PS_IDLE;
    endcase
    if (fin) begin
      n.st = PS_IDLE;
      n.pkt_valid = 1'b1;
      n.pkt_ok = (rsn == RSN_NONE);
      n.pkt_variant = var_c;
      n.pkt_reason = rsn;
    end
    n.reason = rsn;
    n.variant = var_c;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= CORE_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  // no stall, even right after a discard
  assign in_ready = ce;
  assign blk_valid = r.blk_valid;
  assign blk_class = r.blk_class;
  assign blk_reason = r.blk_reason;
  assign blk_grid = r.blk_grid;
  assign blk_index = r.blk_index;
  assign lowest_seq = r.blk_seq;
  assign blk_stride = r.blk_stride;
  assign blk_rep = r.blk_rep;
  assign blk_span = r.blk_span;
  assign blk_ssrc = r.blk_ssrc;
  assign pkt_valid = r.pkt_valid;
  assign pkt_ok = r.pkt_ok;
  assign pkt_variant = r.pkt_variant;
  assign pkt_reason = r.pkt_reason;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_field_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ce && r.st == PS_BLK && in_valid) |-> blk_valid &&
      blk_stride == $past(in_data[15:8]) && blk_rep == $past(in_data[7:0]))
    else $error("grid fields not captured");
  a_block_index: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ce && r.st == PS_BLK && in_valid) |-> blk_index == $past(r.blk_num))
    else $error("block index wrong");
  a_zero_grid_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_stride == 8'h00 |->
      blk_class == CLS_DROP && blk_reason == RSN_ZERO_GRID)
    else $error("zero grid not discarded");
  a_unit_grid_retx: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_stride == 8'h01 && blk_rep == 8'h00 &&
      blk_reason != RSN_WINDOW |-> blk_class == CLS_RETX)
    else $error("unit grid not retransmission");
  a_window_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_class != CLS_DROP |->
      ({16'h0000, blk_span} * {16'h0000, r.pkt_us}) <= r.window)
    else $error("block beyond window kept");
  a_retx_ssrc: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ce && r.st == PS_SSRC && in_valid) |-> blk_valid && !blk_grid &&
      blk_class == CLS_RETX && blk_ssrc == $past(in_data) && blk_span == 16'h0001)
    else $error("retransmission stream wrong");
  a_reserved_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && r.st == PS_IDLE && r.en && in_valid && in_sop &&
      r.scheme == `SCHEME_XOR && in_data[31:30] == 2'h3 |=>
      !blk_valid && r.reason == RSN_RESERVED)
    else $error("reserved variant not ignored");
  a_scheme_default: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && r.st == PS_IDLE && r.en && in_valid && in_sop &&
      r.scheme != `SCHEME_XOR |=> r.reason == RSN_SCHEME)
    else $error("foreign scheme decoded");
  a_row_span: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_stride > 8'h01 && blk_rep == 8'h00 &&
      blk_reason != RSN_WINDOW |-> blk_class == CLS_ROW && blk_span == {8'h00, blk_stride})
    else $error("row span wrong");
  a_row_col_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_stride != 8'h00 && blk_rep == 8'h01 &&
      blk_reason != RSN_WINDOW |-> blk_class == CLS_ROW2D && blk_span == {8'h00, blk_stride})
    else $error("two-dimensional mode wrong");
  a_col_span: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_valid && blk_grid && blk_stride != 8'h00 && blk_rep > 8'h01 &&
      blk_reason != RSN_WINDOW |-> blk_class == CLS_COL && blk_span ==
      16'({8'h00, blk_rep - 8'h01} * {8'h00, blk_stride}) + 16'h0001)
    else $error("column span wrong");
  a_drop_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    pkt_valid && !pkt_ok |-> r.st == PS_IDLE && in_ready == ce)
    else $error("not ready after discard");
  a_pkt_verdict: assert property (@(posedge hclk) disable iff (!hresetn)
    pkt_valid |-> pkt_ok == (pkt_reason == RSN_NONE) &&
      (!pkt_ok || (pkt_variant != CLS_NONE && pkt_variant != CLS_DROP)))
    else $error("verdict and reason disagree");
endmodule

// ===== src/fec_stats.sv
// Accepted and discarded packet counters
`timescale 1ns/10ps
module fec_stats
  import fec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  fec_if.stat bus
);
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] dis;
  } stats_s;

  stats_s r, n;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    if (bus.clr) begin
      n = '0;
    end
    // Count after clear so a verdict in the clear cycle survives
    if (bus.pkt_done) begin
      if (bus.pkt_ok) begin
        n.acc = n.acc + 32'h0000_0001;
      end else begin
        n.dis = n.dis + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign bus.acc_cnt = r.acc;
  assign bus.dis_cnt = r.dis;

  a_count_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && bus.clr && !bus.pkt_done |=> r.acc == 32'h0 && r.dis == 32'h0)
    else $error("counters not cleared");
endmodule

// ===== testbench/fec_repair_sender.sv
// Remote repair sender model feeding header words to the classifier
`timescale 1ns/10ps
module fec_repair_sender (
  input wire logic hclk,
  input wire logic in_ready,
  output logic in_valid,
  output logic in_sop,
  output logic in_eop,
  output logic [31:0] in_data,
  output logic [3:0] in_csrc_cnt
);
  // ------
  // Staged words, filled by the bench
  // ------
  logic [31:0] w [32];
  logic last [32];
  int stuck = 0;

  initial begin
    in_valid = 1'h0;
    in_sop = 1'h0;
    in_eop = 1'h0;
    in_data = 32'hFFFF_FFFF;
    in_csrc_cnt = 4'h0;
  end

  // whole words, sop after each eop
  task automatic send(input int n, input logic [3:0] cc, input int gap);
    int t;
    for (int k = 0; k < n; k++) begin
      in_valid <= 1'h1;
      in_sop <= (k == 0) ? 1'h1 : last[k-1];
      in_eop <= last[k];
      in_data <= w[k];
      in_csrc_cnt <= cc;
      t = 0;
      do begin
        @(posedge hclk);
        t++;
      end while (in_ready !== 1'h1 && t < 20);
      if (in_ready !== 1'h1) begin
        stuck++;
      end
      // Idle data inverted so a stale word never looks valid
      if (gap > 0 || k == n - 1) begin
        in_valid <= 1'h0;
        in_sop <= 1'h0;
        in_eop <= 1'h0;
        in_data <= ~w[k];
        repeat (gap) @(posedge hclk);
      end
    end
  endtask
endmodule

// ===== testbench/test_fec_repair_header_classifier.sv
// Self-checking bench for the repair header classifier
`timescale 1ns/10ps
module test_fec_repair_header_classifier
  import fec_pkg::*;
;
  typedef struct packed {
    logic [7:0] l;
    logic [7:0] d;
    class_e c;
    reason_e r;
    logic [15:0] s;
  } row_s;
  typedef struct packed {
    class_e c;
    reason_e r;
    logic g;
    logic [3:0] i;
    logic [15:0] q;
    logic [7:0] l;
    logic [7:0] d;
    logic [15:0] s;
    logic [31:0] id;
  } blk_rec_s;
  typedef struct packed {
    logic ok;
    class_e v;
    reason_e r;
  } pkt_rec_s;

  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic ce = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic in_valid, in_ready, in_sop, in_eop;
  logic [31:0] in_data;
  logic [3:0] in_csrc_cnt;
  logic blk_valid, blk_grid, pkt_valid, pkt_ok;
  class_e blk_class, pkt_variant;
  reason_e blk_reason, pkt_reason;
  logic [3:0] blk_index;
  logic [15:0] lowest_seq, blk_span;
  logic [7:0] blk_stride, blk_rep;
  logic [31:0] blk_ssrc, rd;
  int failures = 0;
  int total_checks = 0;
  int exp_acc = 0;
  int exp_dis = 0;
  blk_rec_s bq [$];
  pkt_rec_s pq [$];
  row_s rows [8] = '{
    '{8'h00, 8'h00, CLS_DROP, RSN_ZERO_GRID, 16'h0000},
    '{8'h01, 8'h00, CLS_RETX, RSN_NONE, 16'h0001},
    '{8'h05, 8'h00, CLS_ROW, RSN_NONE, 16'h0005},
    '{8'hFF, 8'h01, CLS_ROW2D, RSN_NONE, 16'h00FF},
    '{8'h04, 8'h03, CLS_COL, RSN_NONE, 16'h0009},
    '{8'h63, 8'h66, CLS_COL, RSN_NONE, 16'h2710},
    '{8'h64, 8'h65, CLS_DROP, RSN_WINDOW, 16'h2711},
    '{8'hFF, 8'hFF, CLS_DROP, RSN_WINDOW, 16'hFD03}};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  fec_repair_header_classifier dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .in_valid, .in_ready, .in_sop,
    .in_eop, .in_data, .in_csrc_cnt, .blk_valid, .blk_class, .blk_reason, .blk_grid,
    .blk_index, .lowest_seq, .blk_stride, .blk_rep, .blk_span, .blk_ssrc, .pkt_valid,
    .pkt_ok, .pkt_variant, .pkt_reason);
  fec_repair_sender src (.hclk, .in_ready, .in_valid, .in_sop, .in_eop, .in_data,
    .in_csrc_cnt);

  always @(posedge hclk) begin
    if (blk_valid === 1'h1) begin
      bq.push_back({blk_class, blk_reason, blk_grid, blk_index, lowest_seq, blk_stride,
        blk_rep, blk_span, blk_ssrc});
    end
    if (pkt_valid === 1'h1) begin
      pq.push_back({pkt_ok, pkt_variant, pkt_reason});
    end
  end

  // ------
  // Shared tasks
  // ------
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic step_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    step_rdy();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    step_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic put(input int k, input logic [31:0] v, input logic l);
    src.w[k] = v;
    src.last[k] = l;
  endtask

  // Bounded wait, then two idle edges to catch stray verdicts
  task automatic stream(input int n, input logic [3:0] cc, input int gap, input int np);
    int t;
    bq.delete();
    pq.delete();
    src.send(n, cc, gap);
    t = 0;
    while (pq.size() < np && t < 200) begin
      @(posedge hclk);
      t++;
    end
    if (pq.size() < np) begin
      failures++;
      end_sim();
    end
    repeat (2) @(posedge hclk);
    chk("pkt_count", np, pq.size());
    chk("sender_stall", 0, src.stuck);
  endtask

  task automatic pchk(input int k, input logic ok, input class_e v, input reason_e r);
    chk("pkt_ok", ok, pq[k].ok);
    chk("pkt_variant", v, pq[k].v);
    chk("pkt_reason", r, pq[k].r);
    if (ok) begin
      exp_acc++;
    end else begin
      exp_dis++;
    end
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rchk("ctrl", 8'h00, 32'h1);
    rchk("window", 8'h04, 32'h2710);
    rchk("pkttime", 8'h08, 32'h1);
    rchk("unmapped", 8'h20, 32'h0);
    // grid variant carries the widest spans
    // Grid rows back to back, pair changes every packet
    foreach (rows[i]) begin
      put(3 * i, 32'h4000_0040, 1'h0);
      put(3 * i + 1, 32'h0000_1000 + i, 1'h0);
      put(3 * i + 2, {16'hA000 + i[15:0], rows[i].l, rows[i].d}, 1'h1);
    end
    stream(24, 4'h1, 0, 8);
    foreach (rows[i]) begin
      chk("blk_class", rows[i].c, bq[i].c);
      chk("blk_reason", rows[i].r, bq[i].r);
      chk("blk_span", rows[i].s, bq[i].s);
      chk("lowest_seq", 16'hA000 + i[15:0], bq[i].q);
      chk("stride_rep", {rows[i].l, rows[i].d}, {bq[i].l, bq[i].d});
      chk("blk_grid", 1, bq[i].g);
      pchk(i, rows[i].c != CLS_DROP, rows[i].c, rows[i].r);
    end
    // Two blocks for two streams, slow sender
    put(0, 32'h4000_0010, 1'h0);
    put(1, 32'h0000_2000, 1'h0);
    put(2, 32'h0100_0300, 1'h0);
    put(3, 32'h0200_0204, 1'h1);
    stream(4, 4'h2, 2, 1);
    chk("blk_count", 2, bq.size());
    chk("blk0", {4'h0, CLS_ROW, 16'h0003}, {bq[0].i, bq[0].c, bq[0].s});
    chk("blk1", {4'h1, CLS_COL, 16'h0007}, {bq[1].i, bq[1].c, bq[1].s});
    pchk(0, 1'h1, CLS_ROW, RSN_NONE);
    // retransmission, reserved and mask headers back to back
    put(0, 32'h8000_1234, 1'h0);
    put(1, 32'h0000_3000, 1'h0);
    put(2, 32'hA5A5_0001, 1'h0);
    put(3, 32'h5A5A_0000, 1'h1);
    put(4, 32'hC000_0000, 1'h0);
    put(5, 32'h0000_3001, 1'h1);
    put(6, 32'h0000_0000, 1'h0);
    put(7, 32'h0000_3002, 1'h0);
    put(8, 32'h8000_0001, 1'h1);
    // Header cut after the stamp word
    put(9, 32'h4000_0000, 1'h0);
    put(10, 32'h0000_3003, 1'h1);
    stream(11, 4'h3, 0, 4);
    chk("retx_blocks", 1, bq.size());
    chk("retx_class", {CLS_RETX, 1'h0}, {bq[0].c, bq[0].g});
    chk("retx_seq", 16'h1234, bq[0].q);
    chk("retx_lds", 32'h0000_0001, {bq[0].l, bq[0].d, bq[0].s});
    chk("retx_ssrc", 32'hA5A5_0001, bq[0].id);
    pchk(0, 1'h1, CLS_RETX, RSN_NONE);
    pchk(1, 1'h0, CLS_NONE, RSN_RESERVED);
    pchk(2, 1'h1, CLS_MASK, RSN_NONE);
    pchk(3, 1'h0, CLS_NONE, RSN_TRUNC);
    // Window scales with packet time
    bus(1'h1, 8'h08, 32'h2);
    bus(1'h1, 8'h04, 32'h14);
    put(0, 32'h4000_0000, 1'h0);
    put(1, 32'h0000_4000, 1'h0);
    put(2, 32'hB000_0A00, 1'h1);
    put(3, 32'h4000_0000, 1'h0);
    put(4, 32'h0000_4001, 1'h0);
    put(5, 32'hB001_0B00, 1'h1);
    stream(6, 4'h1, 0, 2);
    pchk(0, 1'h1, CLS_ROW, RSN_NONE);
    pchk(1, 1'h0, CLS_DROP, RSN_WINDOW);
    bus(1'h1, 8'h00, 32'h11);
    stream(3, 4'h1, 0, 1);
    chk("scheme_ok", 0, pq[0].ok);
    chk("scheme_reason", RSN_SCHEME, pq[0].r);
    exp_dis++;
    bus(1'h1, 8'h00, 32'h0);
    stream(3, 4'h1, 0, 0);
    bus(1'h1, 8'h00, 32'h1);
    rchk("status", 8'h0C, 32'h0000_0040);
    rchk("accepted", 8'h10, exp_acc);
    rchk("discarded", 8'h14, exp_dis);
    bus(1'h1, 8'h10, 32'h0);
    rchk("acc_clr", 8'h10, 32'h0);
    rchk("dis_clr", 8'h14, 32'h0);
    // Reset in mid-run restores the window
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    chk("pkt_valid_rst", 0, pkt_valid);
    hresetn <= 1'h1;
    @(posedge hclk);
    rchk("window_rst", 8'h04, 32'h2710);
    rchk("pkttime_rst", 8'h08, 32'h1);
    // Clock enable low stalls both handshakes
    ce <= 1'h0;
    @(posedge hclk);
    chk("ce_stall", 32'h0, {30'h0, hreadyout, in_ready});
    ce <= 1'h1;
    @(posedge hclk);
    chk("ce_run", 32'h3, {30'h0, hreadyout, in_ready});
    end_sim();
  end
endmodule
